/* pkg/tmr_cmp_if.sv */
// tmr_cmp_if: counter, compare values and match results between core and comparator
`timescale 1ns/10ps
interface tmr_cmp_if;
  import tmr_pkg::*;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] cmp_a;
  logic [P_W-1:0]   cmp_p;
  logic             swap;
  logic [CNT_W-1:0] count_inc;
  logic             match_a;
  logic             match_p;
  logic             pwm_active;
  modport core (output count, cmp_a, cmp_p, swap,
                input  count_inc, match_a, match_p, pwm_active);
  modport cmp  (input  count, cmp_a, cmp_p, swap,
                output count_inc, match_a, match_p, pwm_active);
endinterface

/* pkg/tmr_pkg.sv */
// tmr_pkg: register map, field layout and codes of the 10-bit compare/pwm timer
package tmr_pkg;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned P_W   = 3;
  localparam int unsigned DIV_W = 3;
  localparam int unsigned PRE_W = 7;
  localparam int unsigned SPAN_W = 11;
  // bus map
  localparam logic [7:0] OFS_CTRL0   = 8'h00;
  localparam logic [7:0] OFS_CTRL1   = 8'h04;
  localparam logic [7:0] OFS_CNT_LO  = 8'h08;
  localparam logic [7:0] OFS_CNT_HI  = 8'h0c;
  localparam logic [7:0] OFS_CMPA_LO = 8'h10;
  localparam logic [7:0] OFS_CMPA_HI = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  // ctrl0 fields
  localparam int unsigned C0_P_LSB   = 0;
  localparam int unsigned C0_RUN_BIT = 3;
  localparam int unsigned C0_DIV_LSB = 4;
  // ctrl1 fields
  localparam int unsigned C1_CLR_BIT  = 0;
  localparam int unsigned C1_SWAP_BIT = 1;
  localparam int unsigned C1_INV_BIT  = 2;
  localparam int unsigned C1_INIT_BIT = 3;
  localparam int unsigned C1_ACT_LSB  = 4;
  localparam int unsigned C1_MODE_LSB = 6;
  // status fields, write one to clear
  localparam int unsigned ST_A_BIT = 0;
  localparam int unsigned ST_P_BIT = 1;
  // reset values
  localparam logic [7:0]       CTRL0_RST = 8'h00;
  localparam logic [7:0]       CTRL1_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST   = 10'h000;
  localparam logic [CNT_W-1:0] CMPA_RST  = 10'h000;
  // counter geometry
  localparam logic [SPAN_W-1:0] SPAN_FULL = 11'h400;
  localparam logic [6:0]        P_STEP_LO = 7'h00;
  // modes and pin actions
  localparam logic [1:0] MODE_CMP   = 2'h0;
  localparam logic [1:0] MODE_UNDEF = 2'h1;
  localparam logic [1:0] MODE_PWM   = 2'h2;
  localparam logic [1:0] MODE_TMR   = 2'h3;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] ACT_INACT  = 2'h0;
  localparam logic [1:0] ACT_ACTIVE = 2'h1;
  localparam logic [1:0] ACT_PWM    = 2'h2;
  localparam logic [1:0] ACT_PULSE  = 2'h3;
endpackage

/* sim/testbench.sv */
// testbench: scenario checks of the standard timer over apb and its pin
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] %0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench
  import tmr_pkg::*;
;
  logic        clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        oe;
  logic        fa;
  logic        fp;
  logic [11:0] width;
  logic [11:0] period;
  logic [31:0] rd;
  logic        rerr;
  int          err_count;
  int          samples_checked;
  tmr_standard_timer DUT (.i_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_timer_output_pin(pin), .o_timer_output_pin_oe(oe),
    .o_match_a_flag(fa), .o_match_p_flag(fp));
  tmr_pin_load u_load (.i_clk(clk), .i_arst_n(arst_n), .i_pin(pin), .i_pin_oe(oe),
    .o_width(width), .o_period(period));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // config only changes with the timer stopped
  task automatic start(input logic [7:0] c1, input logic [7:0] c0);
    apb(1'b1, OFS_CTRL0, {24'h0, c0});
    apb(1'b1, OFS_STATUS, 32'h3);
    apb(1'b1, OFS_CTRL1, {24'h0, c1});
    apb(1'b1, OFS_CTRL0, {24'h0, c0 | 8'h08});
  endtask
  task automatic wflag(input logic p);
    while ((p ? fp : fa) !== 1'b1) @(posedge clk);
  endtask
  task automatic t_regs;
    for (int i = 2; i < 6; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      `CHK(rd, 32'h0)
    end
    apb(1'b0, 8'h1c, 32'h0);
    `CHK({rd, rerr}, 33'h1)
    apb(1'b1, OFS_CMPA_HI, 32'hff);
    apb(1'b1, OFS_CNT_LO, 32'h77);
    apb(1'b0, OFS_CMPA_HI, 32'h0);
    `CHK(rd, 32'h3)
    apb(1'b0, OFS_CNT_LO, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_compare;
    logic [1:0] act;
    logic       ini;
    logic       inv;
    logic       exp;
    apb(1'b1, OFS_CMPA_HI, 32'h0);
    apb(1'b1, OFS_CMPA_LO, 32'd10);
    for (int i = 0; i < 16; i++)
    begin
      {inv, ini, act} = 4'(i);
      exp = (act == ACT_TOGGLE) ? !ini : (act == ACT_NONE) ? ini : act[1];
      start({MODE_CMP, act, ini, inv, 2'b01}, 8'h00);
      repeat (3) @(posedge clk);
      `CHK(pin, ini ^ inv)
      wflag(1'b0);
      repeat (3) @(posedge clk);
      `CHK(pin, exp ^ inv)
      `CHK(fp, 1'b0)
    end
  endtask
  task automatic t_period_p;
    apb(1'b1, OFS_CMPA_LO, 32'd50);
    start({MODE_CMP, ACT_TOGGLE, 4'h0}, 8'h01);
    wflag(1'b1);
    repeat (3) @(posedge clk);
    `CHK({fa, fp, pin}, 3'b111)
    apb(1'b0, OFS_CNT_LO, 32'h0);
    `CHK(rd < 32'd16, 1'b1)
  endtask
  task automatic t_overflow;
    logic [31:0] held;
    apb(1'b1, OFS_CMPA_LO, 32'h0);
    start({MODE_TMR, 6'h00}, 8'h00);
    repeat (3) @(posedge clk);
    `CHK({oe, pin}, 2'b00)
    wflag(1'b1);
    `CHK(fa, 1'b0)
    apb(1'b1, OFS_CTRL0, 32'h0);
    apb(1'b0, OFS_CNT_LO, 32'h0);
    held = rd;
    repeat (20) @(posedge clk);
    apb(1'b0, OFS_CNT_LO, 32'h0);
    `CHK(rd, held)
    apb(1'b0, OFS_CNT_HI, 32'h0);
    `CHK(rd[31:2], 30'h0)
    apb(1'b1, OFS_CTRL0, 32'h8);
    apb(1'b0, OFS_CNT_LO, 32'h0);
    `CHK(rd < 32'd8, 1'b1)
  endtask
  task automatic t_pwm;
    logic ok;
    apb(1'b1, OFS_CMPA_LO, 32'd32);
    start({MODE_PWM, ACT_PWM, 4'b1001}, 8'h01);
    repeat (400) @(posedge clk);
    `CHK({width, period}, {12'd32, 12'd128})
    `CHK({fa, fp}, 2'b11)
    start({MODE_PWM, ACT_PWM, 4'b1100}, 8'h01);
    repeat (400) @(posedge clk);
    `CHK({width, period}, {12'd96, 12'd128})
    apb(1'b1, OFS_CMPA_LO, 32'd200);
    start({MODE_PWM, ACT_PWM, 4'b1010}, 8'h01);
    repeat (500) @(posedge clk);
    `CHK({width, period}, {12'd128, 12'd200})
    start({MODE_PWM, ACT_PWM, 4'b1000}, 8'h01);
    repeat (5) @(posedge clk);
    ok = 1'b1;
    repeat (260) @(posedge clk) ok &= pin;
    `CHK(ok, 1'b1)
    start({MODE_PWM, ACT_ACTIVE, 4'b1000}, 8'h01);
    repeat (5) @(posedge clk);
    `CHK(pin, 1'b1)
    start({MODE_PWM, ACT_INACT, 4'b1000}, 8'h01);
    repeat (5) @(posedge clk);
    `CHK(pin, 1'b0)
    start({MODE_PWM, ACT_PULSE, 4'b1000}, 8'h01);
    repeat (5) @(posedge clk);
    `CHK(pin, 1'b1)
    wflag(1'b0);
    repeat (3) @(posedge clk);
    apb(1'b0, OFS_CTRL0, 32'h0);
    `CHK({pin, rd[C0_RUN_BIT]}, 2'b00)
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_compare();
    t_period_p();
    t_overflow();
    t_pwm();
    tally_and_finish();
  end
  // whole run is about 3600 clocks
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule // testbench

/* sim/tmr_pin_load.sv */
// tmr_pin_load: load on the timer pin, measures pulse period and high time
`timescale 1ns/10ps
module tmr_pin_load
(
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_arst_n,
  // timer pin
  input  wire logic   i_pin,
  input  wire logic   i_pin_oe,
  // latched at each rising edge of the line
  output logic [11:0] o_width,
  output logic [11:0] o_period
);
  logic        line;
  logic        line_q;
  logic [11:0] cnt_q;
  logic [11:0] hi_q;
  // released line falls to the pull-down
  assign line = i_pin_oe ? i_pin : 1'b0;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      line_q   <= 1'b0;
      cnt_q    <= 12'h0;
      hi_q     <= 12'h0;
      o_width  <= 12'h0;
      o_period <= 12'h0;
    end
    else
    begin
      line_q <= line;
      cnt_q  <= (line && !line_q) ? 12'h1 : cnt_q + 12'h1;
      hi_q   <= (line && !line_q) ? 12'h1 : hi_q + {11'h0, line};
      if (line && !line_q)
      begin
        o_width  <= hi_q;
        o_period <= cnt_q;
      end
    end
  end
endmodule // tmr_pin_load

/* sim/tmr_timer_monitor.sv */
// tmr_timer_monitor: port-level assertions for the standard timer
`timescale 1ns/10ps
module tmr_timer_monitor
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // pin and flags
  input wire logic        o_timer_output_pin,
  input wire logic        o_timer_output_pin_oe,
  input wire logic        o_match_a_flag,
  input wire logic        o_match_p_flag
);
  logic       wr;
  logic       umap;
  logic [1:0] mode_q;
  logic       clr_q;
  logic       lvl_q;
  logic       run_q;
  assign wr   = i_psel & i_penable & i_pwrite;
  assign umap = !(i_paddr inside {OFS_CTRL0, OFS_CTRL1, OFS_CNT_LO, OFS_CNT_HI, OFS_CMPA_LO,
                                 OFS_CMPA_HI, OFS_STATUS});
  // shadow of the control bits, loaded on the same edge as the design
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mode_q <= 2'h0;
      clr_q  <= 1'b0;
      lvl_q  <= 1'b0;
    end
    else if (wr && i_paddr == OFS_CTRL1)
    begin
      mode_q <= i_pwdata[C1_MODE_LSB +: 2];
      clr_q  <= i_pwdata[C1_CLR_BIT];
      lvl_q  <= i_pwdata[C1_INIT_BIT] ^ i_pwdata[C1_INV_BIT];
    end
  end
  // software run bit only; the single pulse self-clear is not seen here
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      run_q <= 1'b0;
    else if (wr && i_paddr == OFS_CTRL0)
      run_q <= i_pwdata[C0_RUN_BIT];
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  a_ready_high: assert property (o_pready)
    else $error("pready dropped");
  a_error_unmapped: assert property (o_pslverr == (i_psel && i_penable && umap))
    else $error("slave error does not follow address decode");
  a_oe_mode: assert property ((run_q && $stable(mode_q)) [*2] |->
    o_timer_output_pin_oe == (mode_q != MODE_TMR))
    else $error("pin enable does not follow mode");
  a_timer_pin_low: assert property ((mode_q == MODE_TMR) [*3] |-> !o_timer_output_pin)
    else $error("pin driven in timer mode");
  a_p_blocked: assert property ($rose(o_match_p_flag) |->
    !($past(mode_q) == MODE_CMP && $past(clr_q)))
    else $error("p flag set with clear on a");
  a_restart_init: assert property ($rose(run_q) && mode_q == MODE_CMP |->
    ##[1:3] o_timer_output_pin == lvl_q)
    else $error("pin not back at initial level");
  a_a_sticky: assert property (o_match_a_flag &&
    !(wr && i_paddr == OFS_STATUS && i_pwdata[ST_A_BIT]) |=> o_match_a_flag)
    else $error("a flag lost");
  a_p_cleared: assert property ($fell(o_match_p_flag) |->
    $past(wr && i_paddr == OFS_STATUS && i_pwdata[ST_P_BIT]))
    else $error("p flag fell without clear");
  a_match_runs: assert property ($rose(o_match_a_flag) |-> $past(run_q))
    else $error("a match while stopped");
endmodule // tmr_timer_monitor

bind tmr_standard_timer tmr_timer_monitor u_mon (.i_clk, .i_arst_n, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_timer_output_pin,
  .o_timer_output_pin_oe, .o_match_a_flag, .o_match_p_flag);

/* verilog/tmr_compare.sv */
// tmr_compare: comparators A and P and the pwm duty decision
`timescale 1ns/10ps
module tmr_compare
  import tmr_pkg::*;
(
  // counter and compare values
  tmr_cmp_if.cmp bus
);
  logic [SPAN_W-1:0] p_span;
  logic [SPAN_W-1:0] duty;

  always_comb
  begin
    bus.count_inc = bus.count + CNT_W'(1);
    // zero compare A never matches, the count just wraps at 3ff
    bus.match_a = (bus.cmp_a != CMPA_RST) && (bus.count_inc == bus.cmp_a);
    if (bus.cmp_p == '0)
    begin
      bus.match_p = (bus.count_inc == CNT_RST);
      p_span      = SPAN_FULL;
    end
    else
    begin
      bus.match_p = (bus.count_inc == {bus.cmp_p, P_STEP_LO});
      p_span      = {1'b0, bus.cmp_p, P_STEP_LO};
    end
    duty = bus.swap ? p_span : {1'b0, bus.cmp_a};
    // duty at or past the period never ends the active phase
    bus.pwm_active = ({1'b0, bus.count} < duty);
  end
endmodule // tmr_compare

/* verilog/tmr_prescaler.sv */
// tmr_prescaler: timer clock enable, one pulse every 2**sel system clocks
`timescale 1ns/10ps
module tmr_prescaler
  import tmr_pkg::*;
(
  // clock and reset
  input  logic             i_clk,
  input  logic             i_arst_n,
  // control
  input  logic [DIV_W-1:0] i_sel,
  input  logic             i_restart,
  // timer clock enable
  output logic             o_tick
);
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] mask;

  assign mask   = PRE_W'((8'h01 << i_sel) - 8'h01);
  assign o_tick = ((pre_q & mask) == mask);

  // restart aligns the first period with the run edge
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pre_q <= '0;
    else if (i_restart)
      pre_q <= '0;
    else
      pre_q <= pre_q + PRE_W'(1);
  end
endmodule // tmr_prescaler

/* verilog/tmr_standard_timer.sv */
// tmr_standard_timer: 10-bit timer with compare, pwm and single pulse output, apb slave
`timescale 1ns/10ps
module tmr_standard_timer
  import tmr_pkg::*;
(
  // clock and reset
  input  logic        i_clk,
  input  logic        i_arst_n,
  // apb slave
  input  logic        i_psel,
  input  logic        i_penable,
  input  logic        i_pwrite,
  input  logic [7:0]  i_paddr,
  input  logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic        o_pready,
  output logic        o_pslverr,
  // timer output pin
  output logic        o_timer_output_pin,
  output logic        o_timer_output_pin_oe,
  // match flags
  output logic        o_match_a_flag,
  output logic        o_match_p_flag
);
  tmr_cmp_if cmp_bus ();

  // configuration
  logic             counter_run_q;
  logic [P_W-1:0]   compare_p_value_q;
  logic [DIV_W-1:0] div_sel_q;
  logic [1:0]       mode_sel_q;
  logic [1:0]       pin_action_q;
  logic             output_initial_level_q;
  logic             output_invert_q;
  logic             duty_period_swap_q;
  logic             clear_source_sel_q;
  logic [CNT_W-1:0] compare_a_value_q;
  // timer state
  logic [CNT_W-1:0] count_q;
  logic             run_prev_q;
  logic             match_a_flag_q;
  logic             match_p_flag_q;
  logic             level_q;
  logic             pin_q;
  logic             pin_oe_q;
  // bus answer
  logic [31:0]      rdata_q;
  logic             slverr_q;
  // decode
  logic             bus_setup;
  logic             bus_write;
  logic             run_rise;
  logic             tick;
  logic             step;
  logic             is_pwm;
  logic             is_pulse;
  logic             cmp_like;
  logic             clear_hit;
  logic             pulse_end;
  logic             set_a;
  logic             set_p;
  logic             pwm_level;
  logic             mapped;
  logic [31:0]      rdata_d;
  logic             ctrl0_wr;
  logic             ctrl1_wr;
  logic             clr_a;
  logic             clr_p;

  assign cmp_bus.count = count_q;
  assign cmp_bus.cmp_a = compare_a_value_q;
  assign cmp_bus.cmp_p = compare_p_value_q;
  assign cmp_bus.swap  = duty_period_swap_q;

  tmr_compare u_compare (
    .bus (cmp_bus.cmp)
  );

  tmr_prescaler u_prescaler (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_sel     (div_sel_q),
    .i_restart (run_rise),
    .o_tick    (tick)
  );

  // zero wait state: read data is latched in the setup cycle
  assign bus_setup = i_psel & ~i_penable;
  assign bus_write = i_psel & i_penable & i_pwrite;
  assign o_pready  = 1'b1;
  assign o_prdata  = rdata_q;
  assign o_pslverr = slverr_q & i_psel & i_penable;

  assign run_rise = counter_run_q & ~run_prev_q;
  assign step     = counter_run_q & ~run_rise & tick;
  assign is_pwm   = (mode_sel_q == MODE_PWM) & (pin_action_q != ACT_PULSE);
  assign is_pulse = (mode_sel_q == MODE_PWM) & (pin_action_q == ACT_PULSE);
  assign cmp_like = (mode_sel_q == MODE_CMP) | (mode_sel_q == MODE_TMR);
  assign ctrl0_wr = bus_write & (i_paddr == OFS_CTRL0);
  assign ctrl1_wr = bus_write & (i_paddr == OFS_CTRL1);
  // write-one-to-clear strobes for the sticky flags
  assign clr_a    = bus_write & (i_paddr == OFS_STATUS) & i_pwdata[ST_A_BIT];
  assign clr_p    = bus_write & (i_paddr == OFS_STATUS) & i_pwdata[ST_P_BIT];

  // period source: swap in pwm, none in single pulse, clear source otherwise
  always_comb
  begin
    if (is_pwm)
      clear_hit = duty_period_swap_q ? cmp_bus.match_a : cmp_bus.match_p;
    else if (is_pulse)
      clear_hit = 1'b0;
    else
      clear_hit = clear_source_sel_q ? cmp_bus.match_a : cmp_bus.match_p;
  end

  assign pulse_end = step & is_pulse & cmp_bus.match_a;

  // flag sources per mode
  always_comb
  begin
    set_a = step & cmp_bus.match_a & (mode_sel_q != MODE_UNDEF);
    if (is_pwm)
      set_p = step & cmp_bus.match_p;
    else if (cmp_like)
      set_p = step & cmp_bus.match_p & ~clear_source_sel_q;
    else
      set_p = 1'b0;
  end

  // pwm and single pulse level before inversion
  always_comb
  begin
    unique case (pin_action_q)
      ACT_INACT:  pwm_level = ~output_initial_level_q;
      ACT_ACTIVE: pwm_level = output_initial_level_q;
      ACT_PWM:    pwm_level = cmp_bus.pwm_active ? output_initial_level_q
                                                 : ~output_initial_level_q;
      ACT_PULSE:  pwm_level = counter_run_q ? output_initial_level_q
                                            : ~output_initial_level_q;
    endcase
  end

  // compare P value, set against the counter's top three bits
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      compare_p_value_q <= CTRL0_RST[C0_P_LSB +: P_W];
    else if (ctrl0_wr)
      compare_p_value_q <= i_pwdata[C0_P_LSB +: P_W];
  end

  // tick divider select; the new mask applies from the next clock, no prescaler restart
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      div_sel_q <= CTRL0_RST[C0_DIV_LSB +: DIV_W];
    else if (ctrl0_wr)
      div_sel_q <= i_pwdata[C0_DIV_LSB +: DIV_W];
  end

  // run bit: a software write wins over the pulse end clearing it
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      counter_run_q <= CTRL0_RST[C0_RUN_BIT];
    else if (bus_write && i_paddr == OFS_CTRL0)
      counter_run_q <= i_pwdata[C0_RUN_BIT];
    else if (pulse_end)
      counter_run_q <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      run_prev_q <= 1'b0;
    else
      run_prev_q <= counter_run_q;
  end

  // control register 1, clear source, swap and pin polarity bits
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      clear_source_sel_q     <= CTRL1_RST[C1_CLR_BIT];
      duty_period_swap_q     <= CTRL1_RST[C1_SWAP_BIT];
      output_invert_q        <= CTRL1_RST[C1_INV_BIT];
      output_initial_level_q <= CTRL1_RST[C1_INIT_BIT];
    end
    else if (ctrl1_wr)
    begin
      clear_source_sel_q     <= i_pwdata[C1_CLR_BIT];
      duty_period_swap_q     <= i_pwdata[C1_SWAP_BIT];
      output_invert_q        <= i_pwdata[C1_INV_BIT];
      output_initial_level_q <= i_pwdata[C1_INIT_BIT];
    end
  end

  // mode and pin action; changes while running are not guarded
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pin_action_q <= CTRL1_RST[C1_ACT_LSB +: 2];
      mode_sel_q   <= CTRL1_RST[C1_MODE_LSB +: 2];
    end
    else if (ctrl1_wr)
    begin
      pin_action_q <= i_pwdata[C1_ACT_LSB +: 2];
      mode_sel_q   <= i_pwdata[C1_MODE_LSB +: 2];
    end
  end

  // compare A value, a low byte and a two-bit high part
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      compare_a_value_q <= CMPA_RST;
    else if (bus_write && i_paddr == OFS_CMPA_LO)
      compare_a_value_q[7:0] <= i_pwdata[7:0];
    else if (bus_write && i_paddr == OFS_CMPA_HI)
      compare_a_value_q[9:8] <= i_pwdata[1:0];
  end

  // counter; a clear replaces the increment, so the period is exact
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      count_q <= CNT_RST;
    else if (run_rise)
      count_q <= CNT_RST;
    else if (step)
      count_q <= clear_hit ? CNT_RST : cmp_bus.count_inc;
  end

  // sticky flags, hardware set wins over a write-one clear
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      match_a_flag_q <= 1'b0;
    else if (set_a)
      match_a_flag_q <= 1'b1;
    else if (clr_a)
      match_a_flag_q <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      match_p_flag_q <= 1'b0;
    else if (set_p)
      match_p_flag_q <= 1'b1;
    else if (clr_p)
      match_p_flag_q <= 1'b0;
  end

  // compare mode level; only A matches move it
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      level_q <= 1'b0;
    else if (run_rise)
      level_q <= output_initial_level_q;
    else if (step && cmp_bus.match_a && mode_sel_q == MODE_CMP)
    begin
      unique case (pin_action_q)
        ACT_NONE:   level_q <= level_q;
        ACT_LOW:    level_q <= output_initial_level_q ? 1'b0 : level_q;
        ACT_HIGH:   level_q <= output_initial_level_q ? level_q : 1'b1;
        ACT_TOGGLE: level_q <= ~level_q;
      endcase
    end
  end

  // pin enable; timer mode releases the pin to other functions
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pin_oe_q <= 1'b0;
    else
      pin_oe_q <= (mode_sel_q != MODE_TMR);
  end

  // released data parks low so a later enable starts from a known level
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pin_q <= 1'b0;
    else if (mode_sel_q == MODE_TMR)
      pin_q <= 1'b0;
    else if (mode_sel_q == MODE_PWM)
      pin_q <= pwm_level ^ output_invert_q;
    else
      pin_q <= level_q ^ output_invert_q;
  end

  assign o_timer_output_pin    = pin_q;
  assign o_timer_output_pin_oe = pin_oe_q;
  assign o_match_a_flag        = match_a_flag_q;
  assign o_match_p_flag        = match_p_flag_q;

  // read mux
  always_comb
  begin
    rdata_d = '0;
    mapped  = 1'b1;
    unique case (i_paddr)
      OFS_CTRL0:
      begin
        rdata_d[C0_P_LSB +: P_W]     = compare_p_value_q;
        rdata_d[C0_RUN_BIT]          = counter_run_q;
        rdata_d[C0_DIV_LSB +: DIV_W] = div_sel_q;
      end
      OFS_CTRL1:
      begin
        rdata_d[C1_CLR_BIT]         = clear_source_sel_q;
        rdata_d[C1_SWAP_BIT]        = duty_period_swap_q;
        rdata_d[C1_INV_BIT]         = output_invert_q;
        rdata_d[C1_INIT_BIT]        = output_initial_level_q;
        rdata_d[C1_ACT_LSB +: 2]    = pin_action_q;
        rdata_d[C1_MODE_LSB +: 2]   = mode_sel_q;
      end
      OFS_CNT_LO:  rdata_d[7:0] = count_q[7:0];
      OFS_CNT_HI:  rdata_d[1:0] = count_q[9:8];
      OFS_CMPA_LO: rdata_d[7:0] = compare_a_value_q[7:0];
      OFS_CMPA_HI: rdata_d[1:0] = compare_a_value_q[9:8];
      OFS_STATUS:
      begin
        rdata_d[ST_A_BIT] = match_a_flag_q;
        rdata_d[ST_P_BIT] = match_p_flag_q;
      end
      default:     mapped = 1'b0;
    endcase
  end

  // answer captured at setup, held through the access cycle
  // a counter read therefore shows the count of the setup edge
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rdata_q <= '0;
    else if (bus_setup)
      rdata_q <= i_pwrite ? 32'h0000_0000 : rdata_d;
  end

  // error is kept apart from data; it is gated to the access phase
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      slverr_q <= 1'b0;
    else if (bus_setup)
      slverr_q <= ~mapped;
  end
endmodule // tmr_standard_timer
